// ### src/cfas_top.sv
// module: filter assist capture, sleep and wakeup control, test mode line routing
// Operation
// - each standard-ID reception outside sleep loads received ID into register
// - read gives ID index byte and one-hot
// - only standard 11-bit identifiers are captured
// - no channel clock, no activity in sleep
// - falling receive edge in sleep raises wakeup
// - leaving sleep restores prior reset or halt
// - test codes: listen, external, internal loop-back
// - listen-only receives, sends recessive, never starts
// - listen-only dominant bits looped back internally
// - external loop-back stores own returned frames
// - external loop-back generates its own acknowledge
// - internal loop-back feeds transmit to receive
// - internal loop-back ignores input, pin recessive
// - internal loop-back needs nothing on pins
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
module cfas_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [cfas_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [cfas_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic lineReceivePin,
  output logic lineTransmitPin,
  input wire logic engineTxBit,
  output logic engineRxBit,
  output logic engineTxStartAllow,
  output logic engineSelfAck,
  output logic engineStoreOwn,
  input wire logic rxFrameDone,
  input wire logic [10:0] rxFrameId,
  input wire logic rxFrameExtended,
  output logic chanClkEn,
  output logic chanResetMode,
  output logic chanHaltMode,
  output logic wakeupIrq
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic rxSyncA;
    logic rxSyncB;
    logic rxPrev;
    logic enable;
    logic wakeEn;
    logic [1:0] testMode;
    cfas_pkg::cfas_chan_mode_t mode;
    cfas_pkg::cfas_chan_mode_t preSleep;
    logic [10:0] filtId;
    logic wakeFlag;
    logic wakePulse;
    logic txPin;
  } cfas_top_state_t;
  cfas_top_state_t st;
  cfas_top_state_t next_st;

  logic wrStrobe;
  logic [cfas_pkg::ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic rdStrobe;
  logic [cfas_pkg::ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic lineActive;
  logic muxTxBit;
  logic [7:0] idOneHot;
  logic [7:0] idIndex;
  logic rxFall;
  logic wrCtrl;
  logic wrStat;
  logic wrWake;
  logic [1:0] reqMode;
  logic [1:0] modeCode;

  //////////////////////////////////////////////////////////////////////////////
  // register bus front end
  cfas_axil_slave u_bus (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdStrobe(rdStrobe),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // line routing per test mode
  cfas_line_mux u_mux (
    .testMode(st.testMode),
    .lineActive(lineActive),
    .engineTxBit(engineTxBit),
    .lineRxBit(st.rxSyncB),
    .lineTxBit(muxTxBit),
    .engineRxBit(engineRxBit),
    .selfAck(engineSelfAck),
    .storeOwn(engineStoreOwn),
    .txStartAllow(engineTxStartAllow)
  );

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // current mode as its request code
  function automatic logic [1:0] cfas_mode_code(input cfas_pkg::cfas_chan_mode_t m);
    logic [1:0] code;
    code = cfas_pkg::REQ_OPERATE;
    unique case (m)
      cfas_pkg::CHAN_OPERATE: code = cfas_pkg::REQ_OPERATE;
      cfas_pkg::CHAN_RESET: code = cfas_pkg::REQ_RESET;
      cfas_pkg::CHAN_HALT: code = cfas_pkg::REQ_HALT;
      cfas_pkg::CHAN_SLEEP: code = cfas_pkg::REQ_SLEEP;
    endcase
    return code;
  endfunction

  // request code to awake mode
  function automatic cfas_pkg::cfas_chan_mode_t cfas_awake_mode(input logic [1:0] code);
    cfas_pkg::cfas_chan_mode_t m;
    m = cfas_pkg::CHAN_RESET;
    unique case (code)
      cfas_pkg::REQ_OPERATE: m = cfas_pkg::CHAN_OPERATE;
      cfas_pkg::REQ_RESET: m = cfas_pkg::CHAN_RESET;
      cfas_pkg::REQ_HALT: m = cfas_pkg::CHAN_HALT;
      cfas_pkg::REQ_SLEEP: m = cfas_pkg::CHAN_SLEEP;
    endcase
    return m;
  endfunction

  // one-hot decode of the three low identifier bits
  for (genvar g = 0; g < cfas_pkg::HOT_W; g++) begin : gOneHot
    assign idOneHot[g] = (st.filtId[cfas_pkg::LOW_W-1:0] == 3'(g));
  end
  assign idIndex = st.filtId[cfas_pkg::STD_ID_W-1:cfas_pkg::LOW_W];

  //////////////////////////////////////////////////////////////////////////////
  // decode and outputs
  assign wrCtrl = wrStrobe && (wrAddr == cfas_pkg::OFF_CTRL);
  assign wrStat = wrStrobe && (wrAddr == cfas_pkg::OFF_STAT);
  assign wrWake = wrStrobe && (wrAddr == cfas_pkg::OFF_WAKE);
  assign reqMode = wrData[cfas_pkg::CTRL_MODE_LSB +: 2];
  assign modeCode = cfas_mode_code(st.mode);
  assign lineActive = st.enable && (st.mode == cfas_pkg::CHAN_OPERATE);
  assign rxFall = st.rxPrev && !st.rxSyncB;
  assign chanClkEn = (st.mode != cfas_pkg::CHAN_SLEEP);
  assign chanResetMode = (st.mode == cfas_pkg::CHAN_RESET);
  assign chanHaltMode = (st.mode == cfas_pkg::CHAN_HALT);
  assign lineTransmitPin = st.txPin;
  assign wakeupIrq = st.wakePulse;

  // unmapped offsets answer with an error, known ones accept any write
  always_comb begin
    wrErr = 1'b1;
    if (wrAddr == cfas_pkg::OFF_CTRL || wrAddr == cfas_pkg::OFF_STAT ||
        wrAddr == cfas_pkg::OFF_WAKE || wrAddr == cfas_pkg::OFF_FILT) begin
      wrErr = 1'b0;
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (rdAddr)
      cfas_pkg::OFF_CTRL: begin
        rdData[cfas_pkg::CTRL_EN_BIT] = st.enable;
        rdData[cfas_pkg::CTRL_MODE_LSB +: 2] = modeCode;
        rdData[cfas_pkg::CTRL_TEST_LSB +: 2] = st.testMode;
      end
      cfas_pkg::OFF_STAT: begin
        rdData[cfas_pkg::STAT_MODE_LSB +: 2] = modeCode;
        rdData[cfas_pkg::STAT_SLEEP_BIT] = (st.mode == cfas_pkg::CHAN_SLEEP);
        rdData[cfas_pkg::STAT_WAKE_BIT] = st.wakeFlag;
      end
      cfas_pkg::OFF_WAKE: begin
        rdData[cfas_pkg::WAKE_EN_BIT] = st.wakeEn;
      end
      cfas_pkg::OFF_FILT: begin
        rdData[cfas_pkg::FILT_IDX_LSB +: cfas_pkg::IDX_W] = idIndex;
        rdData[cfas_pkg::FILT_HOT_LSB +: cfas_pkg::HOT_W] = idOneHot;
      end
      default: begin
        rdErr = 1'b1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.wakePulse = 1'b0;
    // receive pin synchroniser, runs on the system clock in every mode
    next_st.rxSyncA = lineReceivePin;
    next_st.rxSyncB = st.rxSyncA;
    next_st.rxPrev = st.rxSyncB;
    // pin driven from the routing, recessive outside operation
    next_st.txPin = muxTxBit;
    // control register: enable bit and mode request
    if (wrCtrl && wrStrb[0]) begin
      next_st.enable = wrData[cfas_pkg::CTRL_EN_BIT];
      if (st.mode == cfas_pkg::CHAN_SLEEP) begin
        if (reqMode != cfas_pkg::REQ_SLEEP) begin
          next_st.mode = st.preSleep;
        end
      end else if (reqMode == cfas_pkg::REQ_SLEEP) begin
        if (st.mode == cfas_pkg::CHAN_RESET || st.mode == cfas_pkg::CHAN_HALT) begin
          next_st.preSleep = st.mode;
          next_st.mode = cfas_pkg::CHAN_SLEEP;
        end
      end else begin
        next_st.mode = cfas_awake_mode(reqMode);
      end
      // test select only taken while halted
      if (st.mode == cfas_pkg::CHAN_HALT) begin
        next_st.testMode = wrData[cfas_pkg::CTRL_TEST_LSB +: 2];
      end
    end
    // wakeup enable
    if (wrWake && wrStrb[0]) begin
      next_st.wakeEn = wrData[cfas_pkg::WAKE_EN_BIT];
    end
    // wakeup flag: write one clears, a new edge in the same cycle wins
    if (wrStat && wrStrb[0] && wrData[cfas_pkg::STAT_WAKE_BIT]) begin
      next_st.wakeFlag = 1'b0;
    end
    if (st.mode == cfas_pkg::CHAN_SLEEP && rxFall) begin
      next_st.wakeFlag = 1'b1;
      next_st.wakePulse = st.wakeEn && st.enable;
    end
    // filter assist capture, frozen while asleep
    if (rxFrameDone && !rxFrameExtended && st.mode != cfas_pkg::CHAN_SLEEP) begin
      next_st.filtId = rxFrameId;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st.rxSyncA <= cfas_pkg::BIT_RECESSIVE;
      st.rxSyncB <= cfas_pkg::BIT_RECESSIVE;
      st.rxPrev <= cfas_pkg::BIT_RECESSIVE;
      st.enable <= cfas_pkg::RST_ENABLE;
      st.wakeEn <= cfas_pkg::RST_WAKE_EN;
      st.testMode <= cfas_pkg::RST_TEST;
      st.mode <= cfas_pkg::CHAN_RESET;
      st.preSleep <= cfas_pkg::CHAN_RESET;
      st.filtId <= cfas_pkg::RST_FILT_ID;
      st.wakeFlag <= 1'b0;
      st.wakePulse <= 1'b0;
      st.txPin <= cfas_pkg::BIT_RECESSIVE;
    end else begin
      st <= next_st;
    end
  end
endmodule // cfas_top

// ### src/cfas_pkg.sv
// package: register map, field layout, reset values and line codes of the channel helper
package cfas_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STD_ID_W = 11;
  localparam int IDX_W = 8;
  localparam int LOW_W = 3;
  localparam int HOT_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_WAKE = 8'h08;
  localparam logic [7:0] OFF_FILT = 8'h0c;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_TEST_LSB = 3;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_WAKE_BIT = 3;
  localparam int WAKE_EN_BIT = 0;
  localparam int FILT_HOT_LSB = 0;
  localparam int FILT_IDX_LSB = 8;
  // mode request codes in the control register
  localparam logic [1:0] REQ_OPERATE = 2'h0;
  localparam logic [1:0] REQ_RESET = 2'h1;
  localparam logic [1:0] REQ_HALT = 2'h2;
  localparam logic [1:0] REQ_SLEEP = 2'h3;
  // test mode select codes
  localparam logic [1:0] TEST_NONE = 2'h0;
  localparam logic [1:0] TEST_LISTEN = 2'h1;
  localparam logic [1:0] TEST_EXTLOOP = 2'h2;
  localparam logic [1:0] TEST_INTLOOP = 2'h3;
  // values after reset
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_WAKE_EN = 1'b0;
  localparam logic [1:0] RST_TEST = 2'h0;
  localparam logic [10:0] RST_FILT_ID = 11'h000;
  // line levels and bus answers
  localparam logic BIT_RECESSIVE = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {CHAN_OPERATE, CHAN_RESET, CHAN_HALT, CHAN_SLEEP} cfas_chan_mode_t;
endpackage

// ### src/cfas_line_mux.sv
// module: routes the line pins and the protocol engine bits for each test mode
module cfas_line_mux (
  input wire logic [1:0] testMode,
  input wire logic lineActive,
  input wire logic engineTxBit,
  input wire logic lineRxBit,
  output logic lineTxBit,
  output logic engineRxBit,
  output logic selfAck,
  output logic storeOwn,
  output logic txStartAllow
);
  // per-mode routing, recessive on the pin whenever the channel is idle
  always_comb begin
    lineTxBit = cfas_pkg::BIT_RECESSIVE;
    engineRxBit = lineRxBit;
    selfAck = 1'b0;
    storeOwn = 1'b0;
    txStartAllow = lineActive;
    unique case (testMode)
      cfas_pkg::TEST_NONE: begin
        lineTxBit = lineActive ? engineTxBit : cfas_pkg::BIT_RECESSIVE;
      end
      cfas_pkg::TEST_LISTEN: begin
        engineRxBit = lineRxBit & engineTxBit;
        txStartAllow = 1'b0;
      end
      cfas_pkg::TEST_EXTLOOP: begin
        lineTxBit = lineActive ? engineTxBit : cfas_pkg::BIT_RECESSIVE;
        selfAck = 1'b1;
        storeOwn = 1'b1;
      end
      cfas_pkg::TEST_INTLOOP: begin
        engineRxBit = engineTxBit;
        selfAck = 1'b1;
        storeOwn = 1'b1;
      end
    endcase
    if (!lineActive) begin
      engineRxBit = cfas_pkg::BIT_RECESSIVE;
    end
  end
endmodule // cfas_line_mux

// ### src/cfas_axil_slave.sv
// module: AXI4-Lite slave front end giving one-cycle register strobes
module cfas_axil_slave (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [cfas_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [cfas_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrStrobe,
  output logic [cfas_pkg::ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic rdStrobe,
  output logic [cfas_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  typedef struct packed {
    logic awHeld;
    logic [cfas_pkg::ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } cfas_axil_state_t;
  cfas_axil_state_t st;
  cfas_axil_state_t next_st;

  // channel handshakes and strobes toward the register file
  assign awready = !st.awHeld && !st.bValid;
  assign wready = !st.wHeld && !st.bValid;
  assign arready = !st.rValid;
  assign wrStrobe = st.awHeld && st.wHeld && !st.bValid;
  assign wrAddr = st.awAddr;
  assign wrData = st.wData;
  assign wrStrb = st.wStrb;
  assign rdStrobe = arvalid && !st.rValid;
  assign rdAddr = araddr;
  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign rvalid = st.rValid;
  assign rdata = st.rData;
  assign rresp = st.rResp;

  // next state: hold address and data in either order, answer after both
  always_comb begin
    next_st = st;
    if (awvalid && awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (wrStrobe) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = wrErr ? cfas_pkg::RESP_SLVERR : cfas_pkg::RESP_OKAY;
    end else if (st.bValid && bready) begin
      next_st.bValid = 1'b0;
    end
    if (rdStrobe) begin
      next_st.rValid = 1'b1;
      next_st.rData = rdData;
      next_st.rResp = rdErr ? cfas_pkg::RESP_SLVERR : cfas_pkg::RESP_OKAY;
    end else if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // cfas_axil_slave

// ### verification/cfas_sva.sv
// checker: port timing relations of the channel helper
module cfas_sva (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic awready,
  input wire logic wready,
  input wire logic arready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic lineReceivePin,
  input wire logic lineTransmitPin,
  input wire logic engineTxStartAllow,
  input wire logic engineSelfAck,
  input wire logic engineStoreOwn,
  input wire logic chanClkEn,
  input wire logic chanResetMode,
  input wire logic chanHaltMode,
  input wire logic wakeupIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic wasHalt;
  ////////////////////////////////////////////////////////////////
  // mode held just before the clock was gated
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wasHalt <= 1'h0;
    end else if (chanClkEn) begin
      wasHalt <= chanHaltMode;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_sleepQuiet;
    !chanClkEn |-> !chanResetMode && !chanHaltMode && !engineTxStartAllow && lineTransmitPin;
  endproperty
  a_sleepQuiet: assert property (p_sleepQuiet)
    else $error("channel active while clock gated");
  property p_sleepReturn;
    $rose(chanClkEn) |-> chanHaltMode == wasHalt && chanResetMode == !wasHalt;
  endproperty
  a_sleepReturn: assert property (p_sleepReturn)
    else $error("wrong mode after sleep");
  property p_wakeAlign;
    wakeupIrq |-> !chanClkEn && !$past(lineReceivePin, 3) && ($past(lineReceivePin, 4) || $past(lineReceivePin, 5));
  endproperty
  a_wakeAlign: assert property (p_wakeAlign)
    else $error("wakeup without falling line");
  property p_wakePulse;
    wakeupIrq |=> !wakeupIrq;
  endproperty
  a_wakePulse: assert property (p_wakePulse)
    else $error("wakeup pulse too long");
  property p_listenRecessive;
    !engineTxStartAllow |=> lineTransmitPin;
  endproperty
  a_listenRecessive: assert property (p_listenRecessive)
    else $error("dominant bit without start allowed");
  property p_loopPair;
    engineSelfAck == engineStoreOwn;
  endproperty
  a_loopPair: assert property (p_loopPair)
    else $error("loop-back controls disagree");
  property p_bRefuse;
    bvalid |-> !awready && !wready;
  endproperty
  a_bRefuse: assert property (p_bRefuse)
    else $error("write taken during response");
  property p_rRefuse;
    rvalid |-> !arready;
  endproperty
  a_rRefuse: assert property (p_rRefuse)
    else $error("read taken during response");
  property p_bOnce;
    bvalid && bready |=> !bvalid;
  endproperty
  a_bOnce: assert property (p_bOnce)
    else $error("write response repeated");
  c_wake: cover property (wakeupIrq);
  c_return: cover property ($rose(chanClkEn) && chanHaltMode);
  c_loop: cover property (engineSelfAck && !lineTransmitPin);
endmodule // cfas_sva

// ### verification/cfas_bus_model.sv
// model: transceiver and bus seen from the channel pins
module cfas_bus_model (
  input wire logic clk_sys,
  input wire logic txPin,
  input wire logic nodeDominant,
  input wire logic slowEcho,
  output logic rxPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic echoA = 1'h1;
  // wired-and of own echo and other node, bus pulled recessive
  always @(posedge clk_sys) begin
    echoA <= txPin & ~nodeDominant;
    rxPin <= slowEcho ? echoA : (txPin & ~nodeDominant);
  end
endmodule // cfas_bus_model

// ### verification/cfas_top_tb_top.sv
// testbench: registers, capture, test modes and sleep of the channel helper
module cfas_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [10:0] id; logic ext; logic acc; logic [31:0] exp;} cfas_row_t;
  logic clk_sys = 1'h0, rstn = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, lastRd;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
  logic awready, wready, arready, bvalid, rvalid, seen;
  logic [1:0] bresp, rresp, pre;
  logic lineReceivePin, lineTransmitPin, engineRxBit, engineTxStartAllow, engineSelfAck, engineStoreOwn;
  logic engineTxBit = 1'h1, rxFrameDone = 1'h0, rxFrameExtended = 1'h0, nodeDominant = 1'h0, slowEcho = 1'h0;
  logic [10:0] rxFrameId = 11'h0;
  logic chanClkEn, chanResetMode, chanHaltMode, wakeupIrq;
  logic [7:0] tbl [256];
  int numErrors = 0, samplesChecked = 0;
  // captured ids with expected register words and table verdicts
  cfas_row_t rows [6] = '{'{11'h6f3, 1'h0, 1'h1, 32'hde08}, '{11'h00d, 1'h0, 1'h1, 32'h0120},
    '{11'h6f4, 1'h0, 1'h1, 32'hde10}, '{11'h6fe, 1'h0, 1'h0, 32'hdf40}, '{11'h7ff, 1'h1, 1'h0, 32'hdf40},
    '{11'h000, 1'h0, 1'h1, 32'h0001}};
  // per test code: {start, selfAck, storeOwn, pin, rxBit} for engine-dominant and node-dominant stimulus
  logic [4:0] modeExp [4][2] = '{'{5'h10, 5'h12}, '{5'h02, 5'h02}, '{5'h1c, 5'h1e}, '{5'h1e, 5'h1f}};
  always #50 clk_sys = ~clk_sys;
  cfas_top dut (.clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .lineReceivePin(lineReceivePin), .lineTransmitPin(lineTransmitPin),
    .engineTxBit(engineTxBit), .engineRxBit(engineRxBit), .engineTxStartAllow(engineTxStartAllow),
    .engineSelfAck(engineSelfAck), .engineStoreOwn(engineStoreOwn), .rxFrameDone(rxFrameDone),
    .rxFrameId(rxFrameId), .rxFrameExtended(rxFrameExtended), .chanClkEn(chanClkEn),
    .chanResetMode(chanResetMode), .chanHaltMode(chanHaltMode), .wakeupIrq(wakeupIrq));
  cfas_bus_model bus (.clk_sys(clk_sys), .txPin(lineTransmitPin), .nodeDominant(nodeDominant),
    .slowEcho(slowEcho), .rxPin(lineReceivePin));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] t);
    return {27'h0, t, m, 1'h1};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write with both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awOk, wOk;
    awOk = 1'h0;
    wOk = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(awOk && wOk)) begin
      @(posedge clk_sys);
      if (!awOk && awready) begin
        awOk = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wOk && wready) begin
        wOk = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'h1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk_sys); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk_sys); while (rvalid !== 1'h1);
    lastRd = rdata;
    chk(what, ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic frame(input logic [10:0] id, input logic ext);
    rxFrameId <= id;
    rxFrameExtended <= ext;
    rxFrameDone <= 1'h1;
    @(posedge clk_sys);
    rxFrameDone <= 1'h0;
  endtask
  task automatic reportAndStop;
    $display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // software table of accepted ids
  initial begin
    foreach (tbl[i]) tbl[i] = 8'h0;
    foreach (rows[i]) if (rows[i].acc) tbl[rows[i].id[10:3]] |= 8'h01 << rows[i].id[2:0];
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    chk("resetMode", 32'h1, {31'h0, chanResetMode});
    rd("ctrl", cfas_pkg::OFF_CTRL, 32'h2, cfas_pkg::RESP_OKAY);
    rd("stat", cfas_pkg::OFF_STAT, 32'h1, cfas_pkg::RESP_OKAY);
    rd("wake", cfas_pkg::OFF_WAKE, 32'h0, cfas_pkg::RESP_OKAY);
    rd("gap", 8'h10, 32'h0, cfas_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1, cfas_pkg::RESP_SLVERR);
    wr(cfas_pkg::OFF_FILT, 32'hffff, cfas_pkg::RESP_OKAY);
    rd("filt", cfas_pkg::OFF_FILT, 32'h1, cfas_pkg::RESP_OKAY);
    $display("test reset done");
    foreach (rows[i]) begin
      frame(rows[i].id, rows[i].ext);
      rd("filt", cfas_pkg::OFF_FILT, rows[i].exp, cfas_pkg::RESP_OKAY);
      chk("accept", {31'h0, rows[i].acc}, {31'h0, |(tbl[lastRd[15:8]] & lastRd[7:0])});
    end
    $display("test filter done");
    wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_RESET, cfas_pkg::TEST_LISTEN), cfas_pkg::RESP_OKAY);
    rd("ctrl", cfas_pkg::OFF_CTRL, 32'h3, cfas_pkg::RESP_OKAY);
    wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_HALT, 2'h0), cfas_pkg::RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_HALT, 2'(m)), cfas_pkg::RESP_OKAY);
      wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_OPERATE, 2'(m)), cfas_pkg::RESP_OKAY);
      for (int s = 0; s < 2; s++) begin
        engineTxBit <= 1'(s); // engine bit dominant at s 0, recessive at s 1, no transmit request
        nodeDominant <= 1'(s);
        slowEcho <= 1'(s);
        repeat (8) @(posedge clk_sys);
        chk("route", {27'h0, modeExp[m][s]}, {27'h0, engineTxStartAllow, engineSelfAck, engineStoreOwn,
          lineTransmitPin, engineRxBit});
      end
      wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_HALT, 2'(3 - m)), cfas_pkg::RESP_OKAY);
      rd("ctrl", cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_HALT, 2'(m)), cfas_pkg::RESP_OKAY);
    end
    engineTxBit <= 1'h1;
    nodeDominant <= 1'h0;
    $display("test modes done");
    wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_HALT, 2'h0), cfas_pkg::RESP_OKAY);
    wr(cfas_pkg::OFF_WAKE, 32'h1, cfas_pkg::RESP_OKAY);
    wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_OPERATE, 2'h0), cfas_pkg::RESP_OKAY);
    wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_SLEEP, 2'h0), cfas_pkg::RESP_OKAY);
    chk("sleepOperate", 32'h1, {31'h0, chanClkEn});
    for (int k = 0; k < 3; k++) begin
      pre = k ? cfas_pkg::REQ_HALT : cfas_pkg::REQ_RESET;
      wr(cfas_pkg::OFF_WAKE, {31'h0, k != 2}, cfas_pkg::RESP_OKAY);
      wr(cfas_pkg::OFF_CTRL, ctl(pre, 2'h0), cfas_pkg::RESP_OKAY);
      wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_SLEEP, 2'h0), cfas_pkg::RESP_OKAY);
      chk("clkEn", 32'h0, {31'h0, chanClkEn});
      frame(11'h123, 1'h0);
      rd("filtAsleep", cfas_pkg::OFF_FILT, 32'h1, cfas_pkg::RESP_OKAY);
      nodeDominant <= 1'h1;
      seen = 1'h0;
      repeat (10) begin
        @(posedge clk_sys);
        seen = seen | wakeupIrq;
      end
      chk("wakeIrq", {31'h0, k != 2}, {31'h0, seen});
      rd("stat", cfas_pkg::OFF_STAT, 32'hf, cfas_pkg::RESP_OKAY);
      nodeDominant <= 1'h0;
      wr(cfas_pkg::OFF_CTRL, ctl(cfas_pkg::REQ_OPERATE, 2'h0), cfas_pkg::RESP_OKAY);
      wr(cfas_pkg::OFF_STAT, 32'h8, cfas_pkg::RESP_OKAY);
      rd("statBack", cfas_pkg::OFF_STAT, {30'h0, pre}, cfas_pkg::RESP_OKAY);
    end
    $display("test sleep done");
    frame(11'h6ff, 1'h0);
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    rd("ctrlAgain", cfas_pkg::OFF_CTRL, 32'h2, cfas_pkg::RESP_OKAY);
    rd("filtAgain", cfas_pkg::OFF_FILT, 32'h1, cfas_pkg::RESP_OKAY);
    $display("test second reset done");
    reportAndStop();
  end
  // hang guard well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    numErrors++;
    reportAndStop();
  end
endmodule // cfas_top_tb_top
bind cfas_top cfas_sva chk (.clk_sys(clk_sys), .rstn(rstn), .awready(awready), .wready(wready),
  .arready(arready), .bvalid(bvalid), .bready(bready), .rvalid(rvalid), .lineReceivePin(lineReceivePin),
  .lineTransmitPin(lineTransmitPin), .engineTxStartAllow(engineTxStartAllow), .engineSelfAck(engineSelfAck),
  .engineStoreOwn(engineStoreOwn), .chanClkEn(chanClkEn), .chanResetMode(chanResetMode),
  .chanHaltMode(chanHaltMode), .wakeupIrq(wakeupIrq));
